// ### hdl/vcs_pkg.sv
// shared constants, field layouts and types for the regulator config/status bank
package vcs_pkg;
    // register offsets on the byte register port
    localparam logic [7:0] OFS_ILIM_STATUS = 8'h2D;
    localparam logic [7:0] OFS_ILIM_CONFIG = 8'h2E;
    localparam logic [7:0] OFS_FREQ_STATUS = 8'h2F;
    localparam logic [7:0] OFS_FREQ_CONFIG = 8'h30;
    localparam logic [7:0] OFS_PIN_STATUS  = 8'h32;
    localparam logic [7:0] OFS_PHASE_STAT  = 8'h33;
    localparam logic [7:0] OFS_ZONE_MASK   = 8'h34;
    localparam logic [7:0] OFS_SF_SEL_A    = 8'h46;
    localparam logic [7:0] OFS_SF_SEL_B    = 8'h47;

    // writable bit masks; reserved bits read zero
    localparam logic [7:0] FREQ_CFG_MASK = 8'h1F;
    localparam logic [7:0] ILIM_CFG_MASK = 8'h0F;
    localparam logic [7:0] ZONE_MASK_RW  = 8'h0D;
    localparam logic [7:0] SF_SEL_MASK   = 8'h35;
    localparam logic [7:0] REG_RST       = 8'h00;

    // field positions and widths
    localparam int ILIM_LVL_LSB = 2;
    localparam int FREQ_CODE_W  = 5;
    localparam int FREQ_KHZ_W   = 11;
    localparam int DLY_CYC_W    = 21;

    // power-saving pin status codes
    localparam logic [1:0] PIN_MIDDLE = 2'h0;
    localparam logic [1:0] PIN_LOW    = 2'h1;
    localparam logic [1:0] PIN_HIGH   = 2'h2;

    // per-phase current limit thresholds in mV
    localparam logic [7:0] ILIM_MV_0 = 8'h41;
    localparam logic [7:0] ILIM_MV_1 = 8'h4B;
    localparam logic [7:0] ILIM_MV_2 = 8'h64;
    localparam logic [7:0] ILIM_MV_3 = 8'h86;

    // shutdown delays in ms and the clock rate
    localparam logic [3:0] TRIP_MS_0 = 4'h4;
    localparam logic [3:0] TRIP_MS_1 = 4'h6;
    localparam logic [3:0] TRIP_MS_2 = 4'h8;
    localparam logic [3:0] TRIP_MS_3 = 4'hA;
    localparam int CLK_KHZ = 125000;

    // second-function source selection byte
    typedef struct packed {
        logic [1:0] rsv_hi;
        logic       freq_strap;
        logic       load_line;
        logic       rsv_3;
        logic       phase_current_limit;
        logic       rsv_1;
        logic       phase_threshold;
    } vcs_sf_s;
endpackage : vcs_pkg

// ### hdl/vcs_freq_table.sv
// switching frequency lookup by code and active phase count
`timescale 1ns/1ns
module vcs_freq_table (
    input  wire logic [4:0]  code,
    input  wire logic [1:0]  phase_sel,
    output logic      [10:0] khz
);
    logic [43:0] row;

    // each row holds four, three, two, one phase values, high to low
    always_comb begin
        unique case (code)
            5'h00: row = {11'h0DD, 11'h125, 11'h0DF, 11'h0E8};
            5'h01: row = {11'h0F4, 11'h149, 11'h0F3, 11'h0FC};
            5'h02: row = {11'h10A, 11'h166, 11'h108, 11'h110};
            5'h03: row = {11'h125, 11'h17D, 11'h126, 11'h129};
            5'h04: row = {11'h133, 11'h197, 11'h13D, 11'h142};
            5'h05: row = {11'h14D, 11'h1C2, 11'h14F, 11'h154};
            5'h06: row = {11'h15F, 11'h1E0, 11'h160, 11'h169};
            5'h07: row = {11'h175, 11'h1FE, 11'h17C, 11'h181};
            5'h08: row = {11'h18A, 11'h212, 11'h18F, 11'h19D};
            5'h09: row = {11'h1A5, 11'h232, 11'h1A4, 11'h1B3};
            5'h0A: row = {11'h1C1, 11'h258, 11'h1B4, 11'h1C8};
            5'h0B: row = {11'h1D5, 11'h266, 11'h1C6, 11'h1DE};
            5'h0C: row = {11'h1DF, 11'h277, 11'h1E3, 11'h1F4};
            5'h0D: row = {11'h1FD, 11'h297, 11'h1FC, 11'h1FD};
            5'h0E: row = {11'h206, 11'h2B0, 11'h20E, 11'h206};
            5'h0F: row = {11'h21F, 11'h2D2, 11'h21F, 11'h21C};
            5'h10: row = {11'h245, 11'h315, 11'h247, 11'h242};
            5'h11: row = {11'h289, 11'h35B, 11'h290, 11'h27E};
            5'h12: row = {11'h2C4, 11'h3A2, 11'h2BA, 11'h2BA};
            5'h13: row = {11'h2EF, 11'h3F2, 11'h303, 11'h2F6};
            5'h14: row = {11'h31F, 11'h447, 11'h327, 11'h332};
            5'h15: row = {11'h362, 11'h47B, 11'h35C, 11'h36E};
            5'h16: row = {11'h397, 11'h4D1, 11'h383, 11'h3AA};
            5'h17: row = {11'h3C4, 11'h4EC, 11'h3B6, 11'h3CC};
            5'h18: row = {11'h3E1, 11'h53D, 11'h3EB, 11'h3F6};
            5'h19: row = {11'h423, 11'h55C, 11'h41C, 11'h42B};
            5'h1A: row = {11'h44A, 11'h5AA, 11'h448, 11'h452};
            5'h1B: row = {11'h475, 11'h603, 11'h482, 11'h483};
            5'h1C: row = {11'h4B0, 11'h653, 11'h4B5, 11'h4B1};
            5'h1D: row = {11'h4D4, 11'h652, 11'h4CB, 11'h4DD};
            5'h1E: row = {11'h50B, 11'h68A, 11'h4FA, 11'h500};
            5'h1F: row = {11'h520, 11'h6BC, 11'h524, 11'h532};
        endcase
    end

    // phase_sel 3 means four phases
    always_comb begin
        unique case (phase_sel)
            2'h3: khz = row[43:33];
            2'h2: khz = row[32:22];
            2'h1: khz = row[21:11];
            2'h0: khz = row[10:0];
        endcase
    end
endmodule : vcs_freq_table

// ### hdl/vcs_regs.sv
// config/status register bank of a multiphase regulator controller
`timescale 1ns/1ns
module vcs_regs #(
    parameter logic [20:0] TRIP_CYC_0 = 21'(4 * vcs_pkg::CLK_KHZ),
    parameter logic [20:0] TRIP_CYC_1 = 21'(6 * vcs_pkg::CLK_KHZ),
    parameter logic [20:0] TRIP_CYC_2 = 21'(8 * vcs_pkg::CLK_KHZ),
    parameter logic [20:0] TRIP_CYC_3 = 21'(10 * vcs_pkg::CLK_KHZ)
) (
    input  wire logic        sys_clk,
    input  wire logic        sys_rst,
    input  wire logic        clk_en,
    input  wire logic        en_in,
    input  wire logic [3:0]  freq_strap_index,
    input  wire logic [3:0]  current_limit_strap_code,
    input  wire logic        power_saving_input_low,
    input  wire logic        power_saving_input_high,
    input  wire logic [3:0]  phase_enable_in,
    input  wire logic [7:0]  reg_addr,
    input  wire logic [7:0]  reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [7:0]  reg_rdata,
    output logic             reg_rvalid,
    output logic      [4:0]  freq_code,
    output logic      [10:0] freq_khz,
    output logic      [7:0]  phase_current_limit_mv,
    output logic      [3:0]  trip_shutdown_delay_ms,
    output logic      [20:0] trip_shutdown_delay_cycles,
    output logic      [3:0]  zone_allow
);
    logic              en_q, en_d, en_rise, en_toggle;
    logic [7:0]        fstat_q, fstat_d, fcfg_q, fcfg_d;
    logic [7:0]        ilstat_q, ilstat_d, ilcfg_q, ilcfg_d;
    logic [7:0]        zone_q, zone_d, sfa_q, sfa_d, sfb_q, sfb_d;
    logic [7:0]        pin_q, pin_d, phase_q, phase_d;
    vcs_pkg::vcs_sf_s  sel_q, sel_d;
    logic [4:0]        fcode_q, fcode_d;
    logic [10:0]       khz_q, khz_d;
    logic [7:0]        mv_q, mv_d, rdata_q, rdata_d;
    logic [3:0]        ms_q, ms_d, zallow_q, zallow_d, ilcode;
    logic [20:0]       cyc_q, cyc_d;
    logic              rvalid_q, rvalid_d;
    logic [2:0]        ph_cnt;
    logic [1:0]        ph_sel;

    // table looks up the next code against the present phase count
    vcs_freq_table u_table (
        .code      (fcode_d),
        .phase_sel (ph_sel),
        .khz       (khz_d)
    );

    // count enabled phases; none enabled falls back to the one-phase column
    always_comb begin
        ph_cnt = 3'h0;
        for (int i = 0; i < 4; i++) begin
            ph_cnt = ph_cnt + {2'h0, phase_q[i]};
        end
        ph_sel = (ph_cnt == 3'h0) ? 2'h0 : 2'(ph_cnt - 3'h1);
    end

    // next-state of the whole bank
    always_comb begin
        en_d      = en_in;
        en_rise   = en_in & ~en_q;
        en_toggle = en_in ^ en_q;
        fstat_d   = fstat_q;
        ilstat_d  = ilstat_q;
        fcfg_d    = fcfg_q;
        ilcfg_d   = ilcfg_q;
        zone_d    = zone_q;
        sfa_d     = sfa_q;
        sfb_d     = sfb_q;
        sel_d     = sel_q;
        // strap results are caught only at enable rise
        if (en_rise) begin
            fstat_d  = {3'h0, freq_strap_index, 1'b0};
            ilstat_d = {4'h0, current_limit_strap_code};
        end
        // host writes, reserved bits masked off
        if (reg_wr) begin
            unique case (reg_addr)
                vcs_pkg::OFS_FREQ_CONFIG: fcfg_d  = reg_wdata & vcs_pkg::FREQ_CFG_MASK;
                vcs_pkg::OFS_ILIM_CONFIG: ilcfg_d = reg_wdata & vcs_pkg::ILIM_CFG_MASK;
                vcs_pkg::OFS_ZONE_MASK:   zone_d  = reg_wdata & vcs_pkg::ZONE_MASK_RW;
                vcs_pkg::OFS_SF_SEL_A:    sfa_d   = reg_wdata & vcs_pkg::SF_SEL_MASK;
                vcs_pkg::OFS_SF_SEL_B:    sfb_d   = reg_wdata & vcs_pkg::SF_SEL_MASK;
                default: ;
            endcase
        end
        // source changes only once both copies agree
        if (sfa_d == sfb_d) begin
            sel_d = vcs_pkg::vcs_sf_s'(sfa_d);
        end
        // toggle beats a same-cycle select write
        if (en_toggle) begin
            sfa_d = vcs_pkg::REG_RST;
            sfb_d = vcs_pkg::REG_RST;
            sel_d = vcs_pkg::vcs_sf_s'(vcs_pkg::REG_RST);
        end
        // live pin levels; low taken first if both comparators fire
        if (power_saving_input_low) begin
            pin_d = {6'h00, vcs_pkg::PIN_LOW};
        end else if (power_saving_input_high) begin
            pin_d = {6'h00, vcs_pkg::PIN_HIGH};
        end else begin
            pin_d = {6'h00, vcs_pkg::PIN_MIDDLE};
        end
        phase_d = {4'h0, phase_enable_in};
        // source selection for frequency and current limit
        fcode_d = sel_q.freq_strap ? fcfg_q[4:0] : fstat_q[4:0];
        ilcode  = sel_q.phase_current_limit ? ilcfg_q[3:0] : ilstat_q[3:0];
        unique case (ilcode[3:vcs_pkg::ILIM_LVL_LSB])
            2'h0: mv_d = vcs_pkg::ILIM_MV_0;
            2'h1: mv_d = vcs_pkg::ILIM_MV_1;
            2'h2: mv_d = vcs_pkg::ILIM_MV_2;
            2'h3: mv_d = vcs_pkg::ILIM_MV_3;
        endcase
        unique case (ilcode[1:0])
            2'h0: begin ms_d = vcs_pkg::TRIP_MS_0; cyc_d = TRIP_CYC_0; end
            2'h1: begin ms_d = vcs_pkg::TRIP_MS_1; cyc_d = TRIP_CYC_1; end
            2'h2: begin ms_d = vcs_pkg::TRIP_MS_2; cyc_d = TRIP_CYC_2; end
            2'h3: begin ms_d = vcs_pkg::TRIP_MS_3; cyc_d = TRIP_CYC_3; end
        endcase
        // zones are only restricted while the pin sits low
        zallow_d = (pin_q[1:0] == vcs_pkg::PIN_LOW) ? zone_q[3:0] : 4'hF;
        // read mux; unmapped offsets answer zero
        rvalid_d = reg_rd;
        rdata_d  = rdata_q;
        if (reg_rd) begin
            unique case (reg_addr)
                vcs_pkg::OFS_ILIM_STATUS: rdata_d = ilstat_q;
                vcs_pkg::OFS_ILIM_CONFIG: rdata_d = ilcfg_q;
                vcs_pkg::OFS_FREQ_STATUS: rdata_d = fstat_q;
                vcs_pkg::OFS_FREQ_CONFIG: rdata_d = fcfg_q;
                vcs_pkg::OFS_PIN_STATUS:  rdata_d = pin_q;
                vcs_pkg::OFS_PHASE_STAT:  rdata_d = phase_q;
                vcs_pkg::OFS_ZONE_MASK:   rdata_d = zone_q;
                vcs_pkg::OFS_SF_SEL_A:    rdata_d = sfa_q;
                vcs_pkg::OFS_SF_SEL_B:    rdata_d = sfb_q;
                default:                  rdata_d = vcs_pkg::REG_RST;
            endcase
        end
    end

    // registers; clock enable freezes everything
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            en_q     <= 1'b0;
            fstat_q  <= vcs_pkg::REG_RST;
            fcfg_q   <= vcs_pkg::REG_RST;
            ilstat_q <= vcs_pkg::REG_RST;
            ilcfg_q  <= vcs_pkg::REG_RST;
            zone_q   <= vcs_pkg::REG_RST;
            sfa_q    <= vcs_pkg::REG_RST;
            sfb_q    <= vcs_pkg::REG_RST;
            sel_q    <= vcs_pkg::vcs_sf_s'(vcs_pkg::REG_RST);
            pin_q    <= vcs_pkg::REG_RST;
            phase_q  <= vcs_pkg::REG_RST;
            fcode_q  <= 5'h00;
            khz_q    <= 11'h000;
            mv_q     <= 8'h00;
            ms_q     <= 4'h0;
            cyc_q    <= 21'h000000;
            zallow_q <= 4'h0;
            rdata_q  <= vcs_pkg::REG_RST;
            rvalid_q <= 1'b0;
        end else if (clk_en) begin
            en_q     <= en_d;
            fstat_q  <= fstat_d;
            fcfg_q   <= fcfg_d;
            ilstat_q <= ilstat_d;
            ilcfg_q  <= ilcfg_d;
            zone_q   <= zone_d;
            sfa_q    <= sfa_d;
            sfb_q    <= sfb_d;
            sel_q    <= sel_d;
            pin_q    <= pin_d;
            phase_q  <= phase_d;
            fcode_q  <= fcode_d;
            khz_q    <= khz_d;
            mv_q     <= mv_d;
            ms_q     <= ms_d;
            cyc_q    <= cyc_d;
            zallow_q <= zallow_d;
            rdata_q  <= rdata_d;
            rvalid_q <= rvalid_d;
        end
    end

    assign reg_rdata                  = rdata_q;
    assign reg_rvalid                 = rvalid_q;
    assign freq_code                  = fcode_q;
    assign freq_khz                   = khz_q;
    assign phase_current_limit_mv     = mv_q;
    assign trip_shutdown_delay_ms     = ms_q;
    assign trip_shutdown_delay_cycles = cyc_q;
    assign zone_allow                 = zallow_q;

    // checks beside the logic
    ilim_level_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        clk_en && ilcode[3:2] == 2'h3 |=> mv_q == 8'h86)
        else $error("current limit level wrong");
    trip_delay_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        clk_en && ilcode[1:0] == 2'h0 |=> ms_q == 4'h4 && cyc_q == TRIP_CYC_0)
        else $error("shutdown delay wrong");
    strap_latch_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        clk_en && en_in && !en_q |=> fstat_q == {3'h0, $past(freq_strap_index), 1'b0})
        else $error("strap code not latched");
    strap_even_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        fstat_q[0] == 1'b0 && fstat_q[7:5] == 3'h0)
        else $error("odd strap code");
    freq_lookup_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        clk_en && fcode_d == 5'h1F && ph_sel == 2'h3 |=> khz_q == 11'h520)
        else $error("frequency lookup wrong");
    freq_source_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        clk_en ##0 (sel_q.freq_strap == 1'b0) |=> fcode_q == $past(fstat_q[4:0]))
        else $error("frequency source wrong");
    ilim_source_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        clk_en && sel_q.phase_current_limit && ilcfg_q[1:0] == 2'h2
        |=> ms_q == vcs_pkg::TRIP_MS_2 && cyc_q == TRIP_CYC_2)
        else $error("current limit source dead");
    select_match_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        clk_en && sel_d != sel_q && !en_toggle |-> sfa_d == sfb_d)
        else $error("source changed without match");
    toggle_clear_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        clk_en && (en_in != en_q) |=> sel_q == '0 && sfa_q == 8'h00 && sfb_q == 8'h00)
        else $error("toggle did not restore strap");
    pin_report_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        clk_en && !power_saving_input_low && power_saving_input_high |=> pin_q == 8'h02)
        else $error("pin status wrong");
    phase_report_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        clk_en |=> phase_q == {4'h0, $past(phase_enable_in)})
        else $error("phase status wrong");
    zone_gate_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        clk_en && pin_q == 8'h01 |=> zallow_q == $past(zone_q[3:0]) && !zallow_q[1])
        else $error("zone gating wrong");
    reserved_zero_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        fcfg_q[7:5] == 3'h0 && ilcfg_q[7:4] == 4'h0 && zone_q[7:4] == 4'h0 && !zone_q[1])
        else $error("reserved bits set");
endmodule : vcs_regs

// ### verif/vcs_board.sv
// board-side model: strap resistors, power-saving pin comparators and phase drivers
`timescale 1ns/1ns
module vcs_board (
    input  wire logic [3:0] res_freq_sel,
    input  wire logic [3:0] res_limit_sel,
    input  wire logic [1:0] pin_level,
    input  wire logic [3:0] phase_on,
    output logic      [3:0] freq_strap_index,
    output logic      [3:0] current_limit_strap_code,
    output logic            power_saving_input_low,
    output logic            power_saving_input_high,
    output logic      [3:0] phase_enable_in
);
    // resistor positions map straight to indices; only sixteen positions exist
    always_comb begin
        freq_strap_index         = res_freq_sel;
        current_limit_strap_code = res_limit_sel;
        // comparators never both high, so the low-wins choice is not exercised
        power_saving_input_low   = (pin_level == vcs_pkg::PIN_LOW);
        power_saving_input_high  = (pin_level == vcs_pkg::PIN_HIGH);
        phase_enable_in          = phase_on;
    end
endmodule : vcs_board

// ### verif/test_vr_config_status_regs.sv
// self-checking bench for the regulator config/status register bank
`timescale 1ns/1ns
module test_vr_config_status_regs;
    typedef struct packed {
        logic [3:0]  fidx;
        logic [3:0]  lim;
        logic [10:0] khz;
        logic [7:0]  mv;
        logic [3:0]  ms;
        logic [20:0] cyc;
    } vcs_row_s;

    logic        sys_clk = 1'b0;
    logic        sys_rst = 1'b1;
    logic        clk_en = 1'b1;
    logic        en_in = 1'b0;
    logic [7:0]  reg_addr = 8'h00;
    logic [7:0]  reg_wdata = 8'h00;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic [3:0]  res_freq_sel = 4'h0;
    logic [3:0]  res_limit_sel = 4'h0;
    logic [1:0]  pin_level = 2'h0;
    logic [3:0]  phase_on = 4'hF;
    logic [3:0]  fidx, lcode, ph_en;
    logic        pin_lo, pin_hi, reg_rvalid;
    logic [7:0]  reg_rdata, mv;
    logic [4:0]  freq_code;
    logic [10:0] freq_khz;
    logic [3:0]  ms, zone_allow;
    logic [20:0] dly_cyc;
    int          num_errors = 0;
    int          total_checks = 0;
    int          cycle_cnt = 0;
    vcs_row_s    rows [4];
    logic [3:0]  zexp [3];

    // 125 MHz system clock
    always #4 sys_clk = ~sys_clk;

    vcs_board board_u (.res_freq_sel(res_freq_sel), .res_limit_sel(res_limit_sel),
        .pin_level(pin_level), .phase_on(phase_on), .freq_strap_index(fidx),
        .current_limit_strap_code(lcode), .power_saving_input_low(pin_lo),
        .power_saving_input_high(pin_hi), .phase_enable_in(ph_en));

    // short trip counts keep the delay path visible in a brief run
    vcs_regs #(.TRIP_CYC_0(21'h28), .TRIP_CYC_1(21'h3C), .TRIP_CYC_2(21'h50),
        .TRIP_CYC_3(21'h64)) dut_u (.sys_clk(sys_clk), .sys_rst(sys_rst), .clk_en(clk_en),
        .en_in(en_in), .freq_strap_index(fidx), .current_limit_strap_code(lcode),
        .power_saving_input_low(pin_lo), .power_saving_input_high(pin_hi),
        .phase_enable_in(ph_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
        .freq_code(freq_code), .freq_khz(freq_khz), .phase_current_limit_mv(mv),
        .trip_shutdown_delay_ms(ms), .trip_shutdown_delay_cycles(dly_cyc),
        .zone_allow(zone_allow));

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : tally_and_finish

    task automatic cyc(input int n);
        repeat (n) @(negedge sys_clk);
    endtask : cyc

    task automatic chk_out(input string what, input logic [20:0] exp, input logic [20:0] got);
        total_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD %s expected %0h seen %0h", what, exp, got);
        end
    endtask : chk_out

    // one-cycle strobe driven at the falling edge, answer sampled a cycle later
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        reg_addr = a;
        reg_rd = 1'b1;
        @(negedge sys_clk);
        reg_rd = 1'b0;
        total_checks++;
        if (reg_rvalid !== 1'b1 || reg_rdata !== exp) begin
            num_errors++;
            $display("BAD reg %0h expected %0h seen %0h", a, exp, reg_rdata);
        end
        // idle edge so a following read never re-raises the strobe in this time step
        @(negedge sys_clk);
    endtask : rd_chk

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge sys_clk);
        reg_wr = 1'b0;
    endtask : wr

    // a hang ends the run as a failure
    always @(posedge sys_clk) begin
        cycle_cnt++;
        if (cycle_cnt == 5000) begin
            num_errors++;
            tally_and_finish();
        end
    end

    // main sequence: strap table, then overrides, toggle, pin and phase cases
    initial begin
        rows[0] = '{4'h0, 4'h0, 11'h0DD, vcs_pkg::ILIM_MV_0, vcs_pkg::TRIP_MS_0, 21'h28};
        rows[1] = '{4'h1, 4'h5, 11'h10A, vcs_pkg::ILIM_MV_1, vcs_pkg::TRIP_MS_1, 21'h3C};
        rows[2] = '{4'h7, 4'hA, 11'h206, vcs_pkg::ILIM_MV_2, vcs_pkg::TRIP_MS_2, 21'h50};
        rows[3] = '{4'hF, 4'hF, 11'h50B, vcs_pkg::ILIM_MV_3, vcs_pkg::TRIP_MS_3, 21'h64};
        zexp = '{4'hF, 4'hD, 4'hF};
        cyc(2);
        sys_rst = 1'b0;
        cyc(1);
        rd_chk(vcs_pkg::OFS_FREQ_CONFIG, vcs_pkg::REG_RST);
        rd_chk(vcs_pkg::OFS_ZONE_MASK, vcs_pkg::REG_RST);
        rd_chk(8'h31, 8'h00);
        $display("reset test done");
        for (int i = 0; i < 4; i++) begin
            res_freq_sel = rows[i].fidx;
            res_limit_sel = rows[i].lim;
            en_in = 1'b0;
            cyc(2);
            en_in = 1'b1;
            cyc(3);
            rd_chk(vcs_pkg::OFS_FREQ_STATUS, {3'h0, rows[i].fidx, 1'b0});
            rd_chk(vcs_pkg::OFS_ILIM_STATUS, {4'h0, rows[i].lim});
            chk_out("freq_code", 21'({rows[i].fidx, 1'b0}), 21'(freq_code));
            chk_out("freq_khz", 21'(rows[i].khz), 21'(freq_khz));
            chk_out("limit_mv", 21'(rows[i].mv), 21'(mv));
            chk_out("delay_ms", 21'(rows[i].ms), 21'(ms));
            chk_out("delay_cyc", rows[i].cyc, dly_cyc);
            $display("strap row %0d done", i);
        end
        // overrides: one select alone must not switch the source
        wr(vcs_pkg::OFS_FREQ_CONFIG, 8'hFF);
        rd_chk(vcs_pkg::OFS_FREQ_CONFIG, 8'h1F);
        wr(vcs_pkg::OFS_ILIM_CONFIG, 8'hF6);
        rd_chk(vcs_pkg::OFS_ILIM_CONFIG, 8'h06);
        wr(vcs_pkg::OFS_SF_SEL_A, 8'h24);
        cyc(2);
        chk_out("freq_code", 21'h1E, 21'(freq_code));
        wr(vcs_pkg::OFS_SF_SEL_B, 8'h24);
        cyc(2);
        chk_out("freq_code", 21'h1F, 21'(freq_code));
        chk_out("freq_khz", 21'h520, 21'(freq_khz));
        chk_out("limit_mv", 21'(vcs_pkg::ILIM_MV_1), 21'(mv));
        chk_out("delay_cyc", 21'h50, dly_cyc);
        wr(vcs_pkg::OFS_SF_SEL_A, 8'h04);
        cyc(2);
        chk_out("freq_code", 21'h1F, 21'(freq_code));
        wr(vcs_pkg::OFS_SF_SEL_B, 8'h04);
        cyc(2);
        chk_out("freq_code", 21'h1E, 21'(freq_code));
        chk_out("limit_mv", 21'(vcs_pkg::ILIM_MV_1), 21'(mv));
        $display("override test done");
        // enable falls: every source returns to the straps
        en_in = 1'b0;
        cyc(3);
        chk_out("limit_mv", 21'(vcs_pkg::ILIM_MV_3), 21'(mv));
        rd_chk(vcs_pkg::OFS_SF_SEL_B, 8'h00);
        en_in = 1'b1;
        cyc(3);
        $display("toggle test done");
        wr(vcs_pkg::OFS_ZONE_MASK, 8'hFF);
        rd_chk(vcs_pkg::OFS_ZONE_MASK, 8'h0D);
        for (int j = 0; j < 3; j++) begin
            pin_level = 2'(j);
            cyc(3);
            rd_chk(vcs_pkg::OFS_PIN_STATUS, {6'h00, 2'(j)});
            chk_out("zone_allow", 21'(zexp[j]), 21'(zone_allow));
        end
        $display("pin test done");
        // two phases active moves the frequency to its column
        phase_on = 4'h5;
        cyc(3);
        rd_chk(vcs_pkg::OFS_PHASE_STAT, 8'h05);
        chk_out("freq_khz", 21'h4FA, 21'(freq_khz));
        wr(vcs_pkg::OFS_FREQ_STATUS, 8'h00);
        rd_chk(vcs_pkg::OFS_FREQ_STATUS, 8'h1E);
        $display("phase test done");
        // clock enable low: a write in that window must be lost
        clk_en = 1'b0;
        wr(vcs_pkg::OFS_ZONE_MASK, 8'h00);
        clk_en = 1'b1;
        rd_chk(vcs_pkg::OFS_ZONE_MASK, 8'h0D);
        $display("freeze test done");
        // reset in mid-run with enable low, so release brings no strap latch
        en_in = 1'b0;
        sys_rst = 1'b1;
        cyc(2);
        sys_rst = 1'b0;
        cyc(1);
        rd_chk(vcs_pkg::OFS_ZONE_MASK, vcs_pkg::REG_RST);
        chk_out("freq_code", 21'h00, 21'(freq_code));
        chk_out("limit_mv", 21'(vcs_pkg::ILIM_MV_0), 21'(mv));
        chk_out("zone_allow", 21'hF, 21'(zone_allow));
        $display("second reset test done");
        tally_and_finish();
    end
endmodule : test_vr_config_status_regs
